/* charger_regs_pkg.sv */
// register map, field layout and reset values of the charger register bank
// assumes one core clock; every consumer imports the whole package
//
// Contract
// - fault mask bit 7 set blocks the input overvoltage interrupt; clear passes it
// - fault mask bit 5 masks battery overcurrent, bit 4 masks battery undervoltage
// - fault mask bits 3..0 mask thermistor cold, cool, warm and hot entries
// - fault mask resets to zero; reserved bit 6 is still writable storage
// - adc mask bit 7 masks conversion-ready; resets to 0
// - adc mask bits 6..4 mask the three comparator alarms; each resets to 1
// - adc mask bit 0 masks thermistor open, resets 1; bits 3..1 stored; reset 0x71
// - timer mask bit 6 masks watchdog expiry; resets to 0
// - timer mask bit 5 masks safety timer expiry, bit 4 regulator overcurrent
// - timer mask bits 2..0 mask button wake one, wake two, reset warning
// - regulation code bits 6..0 select 3.6 V plus 10 mV steps; reset 4.2 V
// - a written regulation code above 4.6 V is stored as the 4.6 V code
// - range clear: fast charge current is 1.25 mA times the code
// - range set: fast charge current is 2.5 mA times the code
// - fast charge code resets to 0x08, 10 mA at the default range
// - precharge bit 7 selects the current step for both charge fields
// - precharge code bits 4..0 scale by the step; resets to 2.5 mA
// - each maskable source owns a flag bit that reads 1 while its event was seen

package charger_regs_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] FAULT_FLAG_OFS     = 8'h04;
    localparam logic [7:0] ADC_FLAG_OFS       = 8'h05;
    localparam logic [7:0] TIMER_FLAG_OFS     = 8'h06;
    localparam logic [7:0] FAULT_IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] ADC_IRQ_MASK_OFS   = 8'h09;
    localparam logic [7:0] TIMER_IRQ_MASK_OFS = 8'h0a;
    localparam logic [7:0] BAT_REG_VOLT_OFS   = 8'h12;
    localparam logic [7:0] FAST_CHARGE_OFS    = 8'h13;
    localparam logic [7:0] PRECHARGE_OFS      = 8'h14;
    localparam logic [7:0] TERMINATION_OFS    = 8'h15;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FAULT_IRQ_MASK_RST = 8'h00;
    localparam logic [7:0] ADC_IRQ_MASK_RST   = 8'h71;
    localparam logic [7:0] TIMER_IRQ_MASK_RST = 8'h00;
    localparam logic [6:0] BAT_REG_CODE_RST   = 7'h3c;
    localparam logic [7:0] FAST_CHARGE_RST    = 8'h08;
    localparam logic [7:0] PRECHARGE_RST      = 8'h02;
    localparam logic [7:0] TERMINATION_RST    = 8'h14;
    localparam logic [7:0] FLAG_RST           = 8'h00;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int         BAT_REG_CODE_W     = 7;
    localparam logic [6:0] BAT_REG_CODE_MAX   = 7'h64;  // 4.6 V
    localparam int         CURRENT_STEP_BIT   = 7;
    localparam int         PRECHARGE_CODE_W   = 5;
    localparam logic [7:0] PRECHARGE_WR_MASK  = 8'h9f;  // bits 6..5 dropped on write, read as zero
    // flag bits that a source can set; reserved flag positions stay zero
    localparam logic [7:0] FAULT_FLAG_VALID   = 8'hbf;
    localparam logic [7:0] ADC_FLAG_VALID     = 8'hf1;
    localparam logic [7:0] TIMER_FLAG_VALID   = 8'h77;
    localparam int         FLAG_GROUPS        = 3;

    // ------------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------------
    localparam logic [2:0] LAST_BIT           = 3'h7;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK
    } link_state_t;

endpackage

/* event_flag_group.sv */
// one group of sticky event flags with its interrupt mask
// assumes events come from logic on the same clock, one bit per source
`timescale 1ns/1ps

module event_flag_group
    import charger_regs_pkg::*;
#(
    parameter int         WIDTH = 8,
    parameter logic [7:0] VALID = 8'hff
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // sources and control
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic             clear,
    // state
    output logic      [WIDTH-1:0] flags,
    output logic                  pending
);

    if (WIDTH != 8) begin : g_width_check
        $error("event_flag_group serves 8-bit groups only");
    end

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // set wins over clear so an event landing on the read is kept
    assign flags_d = (clear ? '0 : flags_q) | (event_in & VALID[WIDTH-1:0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAG_RST[WIDTH-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

    // masked flags stay visible but never raise the interrupt
    assign pending = |(flags_q & ~mask);
    assign flags   = flags_q;

endmodule

/* charger_reg_bank.sv */
// serial-addressed register bank: interrupt masks, event flags, charge set-points
// assumes scl and sda come straight from pins; open-drain sda resolved outside
`timescale 1ns/1ps

module charger_reg_bank
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary target address
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // serial link pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // event sources, one pulse per detected condition
    input  wire logic [7:0] fault_event,
    input  wire logic [7:0] adc_event,
    input  wire logic [7:0] timer_event,
    // interrupt to the host
    output logic            charge_irq_n,
    // charge set-points
    output logic [6:0]      regulation_code,
    output logic [7:0]      fast_charge_code,
    output logic [4:0]      precharge_code,
    output logic            current_step_select,
    output logic [7:0]      termination_cfg,
    output logic [8:0]      fast_charge_units,
    output logic [5:0]      precharge_units
);

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    // reset asserts at once but leaves on the clock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // bit 0 is the metastable stage; only bit 1 feeds logic
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // line events; start and stop are sda moving while scl is high
    assign scl_s      = scl_sync_q[1];
    assign sda_s      = sda_sync_q[1];
    assign scl_rise   = scl_s & ~scl_prev_q;
    assign scl_fall   = ~scl_s & scl_prev_q;
    assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------------
    // serial target state machine
    // ------------------------------------------------------------------
    link_state_t state_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic        full_q;
    logic        rnw_q;
    logic        nack_q;
    logic        ptr_set_q;
    logic [7:0]  ptr_q;
    logic        sda_oe_q;
    logic [7:0]  rd_data;
    logic        rd_load;
    logic        wr_stb;

    // load a byte on the fall ending a read address ack slot or a host-acked read ack slot
    assign rd_load = scl_fall & ((state_q == ST_ADDR_ACK & rnw_q) |
                                 (state_q == ST_READ_ACK & ~nack_q));
    // first written byte sets the pointer; later ones land there, the pointer stepping after each
    assign wr_stb  = scl_fall & full_q & (state_q == ST_WRITE) & ptr_set_q;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q   <= 8'h00;
            full_q    <= 1'b0;
            rnw_q     <= 1'b0;
            nack_q    <= 1'b0;
            ptr_set_q <= 1'b0;
            ptr_q     <= 8'h00;
            sda_oe_q  <= 1'b0;
        end else if (start_seen) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 3'h0;
            full_q    <= 1'b0;
            ptr_set_q <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (stop_seen) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (rd_load) begin
            // read data comes out msb first; pointer steps per byte
            shift_q   <= rd_data;
            sda_oe_q  <= ~rd_data[7];
            bit_cnt_q <= 3'h0;
            ptr_q     <= ptr_q + 8'h01;
            state_q   <= ST_READ;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        full_q    <= (bit_cnt_q == LAST_BIT);
                    end else if (scl_fall && full_q) begin
                        full_q <= 1'b0;
                        if (state_q == ST_ADDR) begin
                            // foreign address: idle until next start
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rnw_q    <= shift_q[0];
                                sda_oe_q <= 1'b1;
                                state_q  <= ST_ADDR_ACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            sda_oe_q  <= 1'b1;
                            state_q   <= ST_WRITE_ACK;
                            ptr_set_q <= 1'b1;
                            ptr_q     <= ptr_set_q ? ptr_q + 8'h01 : shift_q;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        state_q   <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_READ_ACK;
                        end else begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= ~shift_q[6];
                        end
                    end
                end
                ST_READ_ACK: begin
                    // a nack ends the read; the host then stops or restarts
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_q;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] ptr, input logic [7:0] ofs);
        hit = (ptr == ofs);
    endfunction

    // saturate regulation codes above the 4.6 V setting
    function automatic logic [6:0] clamp_reg(input logic [6:0] code);
        clamp_reg = (code > BAT_REG_CODE_MAX) ? BAT_REG_CODE_MAX : code;
    endfunction

    logic [7:0] fault_mask_q;
    logic [7:0] adc_mask_q;
    logic [7:0] timer_mask_q;
    logic [6:0] reg_code_q;
    logic       reg_spare_q;
    logic [7:0] fast_q;
    logic [7:0] pre_q;
    logic [7:0] term_q;

    // masks store whole bytes, reserved bits included
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fault_mask_q <= FAULT_IRQ_MASK_RST;
            adc_mask_q   <= ADC_IRQ_MASK_RST;
            timer_mask_q <= TIMER_IRQ_MASK_RST;
        end else if (wr_stb) begin
            if (hit(ptr_q, FAULT_IRQ_MASK_OFS)) fault_mask_q <= shift_q;
            if (hit(ptr_q, ADC_IRQ_MASK_OFS))   adc_mask_q   <= shift_q;
            if (hit(ptr_q, TIMER_IRQ_MASK_OFS)) timer_mask_q <= shift_q;
        end
    end

    // set-points; the charge path reads these directly
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_code_q  <= BAT_REG_CODE_RST;
            reg_spare_q <= 1'b0;
            fast_q      <= FAST_CHARGE_RST;
            pre_q       <= PRECHARGE_RST;
            term_q      <= TERMINATION_RST;
        end else if (wr_stb) begin
            if (hit(ptr_q, BAT_REG_VOLT_OFS)) begin
                reg_code_q  <= clamp_reg(shift_q[6:0]);
                reg_spare_q <= shift_q[7];
            end
            if (hit(ptr_q, FAST_CHARGE_OFS)) fast_q <= shift_q;
            if (hit(ptr_q, PRECHARGE_OFS))   pre_q  <= shift_q & PRECHARGE_WR_MASK;
            if (hit(ptr_q, TERMINATION_OFS)) term_q <= shift_q;
        end
    end

    // ------------------------------------------------------------------
    // event flags and interrupt
    // ------------------------------------------------------------------
    logic [7:0] ev_a    [FLAG_GROUPS];
    logic [7:0] mask_a  [FLAG_GROUPS];
    logic [7:0] flags_a [FLAG_GROUPS];
    logic [7:0] ofs_a   [FLAG_GROUPS];
    logic [FLAG_GROUPS-1:0] pend;

    assign ev_a[0]   = fault_event;
    assign ev_a[1]   = adc_event;
    assign ev_a[2]   = timer_event;
    // bit n of each mask gates flag n of the same group
    assign mask_a[0] = fault_mask_q;
    assign mask_a[1] = adc_mask_q;
    assign mask_a[2] = timer_mask_q;
    assign ofs_a[0]  = FAULT_FLAG_OFS;
    assign ofs_a[1]  = ADC_FLAG_OFS;
    assign ofs_a[2]  = TIMER_FLAG_OFS;

    for (genvar g = 0; g < FLAG_GROUPS; g++) begin : g_flags
        localparam logic [7:0] VALID = (g == 0) ? FAULT_FLAG_VALID :
                                       (g == 1) ? ADC_FLAG_VALID : TIMER_FLAG_VALID;
        event_flag_group #(
            .WIDTH (8),
            .VALID (VALID)
        ) u_group (
            .clk      (core_clk),
            .rst_n    (rst_n_q),
            .event_in (ev_a[g]),
            .mask     (mask_a[g]),
            .clear    (rd_load & hit(ptr_q, ofs_a[g])),
            .flags    (flags_a[g]),
            .pending  (pend[g])
        );
    end

    logic irq_n_q;

    // registered so the pin never glitches while flags settle
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~|pend;
        end
    end

    assign charge_irq_n = irq_n_q;

    // ------------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------------
    assign rd_data = hit(ptr_q, FAULT_FLAG_OFS)     ? flags_a[0] :
                     hit(ptr_q, ADC_FLAG_OFS)       ? flags_a[1] :
                     hit(ptr_q, TIMER_FLAG_OFS)     ? flags_a[2] :
                     hit(ptr_q, FAULT_IRQ_MASK_OFS) ? fault_mask_q :
                     hit(ptr_q, ADC_IRQ_MASK_OFS)   ? adc_mask_q :
                     hit(ptr_q, TIMER_IRQ_MASK_OFS) ? timer_mask_q :
                     hit(ptr_q, BAT_REG_VOLT_OFS)   ? {reg_spare_q, reg_code_q} :
                     hit(ptr_q, FAST_CHARGE_OFS)    ? fast_q :
                     hit(ptr_q, PRECHARGE_OFS)      ? pre_q :
                     hit(ptr_q, TERMINATION_OFS)    ? term_q : UNMAPPED_READ;

    // ------------------------------------------------------------------
    // set-point outputs
    // ------------------------------------------------------------------
    assign regulation_code     = reg_code_q;
    assign fast_charge_code    = fast_q;
    assign precharge_code      = pre_q[PRECHARGE_CODE_W-1:0];
    assign current_step_select = pre_q[CURRENT_STEP_BIT];
    assign termination_cfg     = term_q;

    // currents in 1.25 mA units, doubled on the coarse step
    assign fast_charge_units = current_step_select ? {fast_q, 1'b0}
                                                   : {1'b0, fast_q};
    assign precharge_units   = current_step_select ? {precharge_code, 1'b0}
                                                   : {1'b0, precharge_code};

endmodule

/* charger_reg_bank_chk.sv */
// checker: output relations of the register bank
// assumes bind onto charger_reg_bank, one core clock domain
`timescale 1ns/1ps
module charger_reg_bank_chk
    import charger_regs_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // watched outputs
    input wire logic       charge_irq_n,
    input wire logic [6:0] regulation_code,
    input wire logic [7:0] fast_charge_code,
    input wire logic [4:0] precharge_code,
    input wire logic       current_step_select,
    input wire logic [7:0] termination_cfg,
    input wire logic [8:0] fast_charge_units,
    input wire logic [5:0] precharge_units
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // registers still hold reset values at release
    sequence s_release;
        $rose(reset_n);
    endsequence
    property p_reg_rst; s_release |-> regulation_code == BAT_REG_CODE_RST; endproperty
    property p_fast_rst; s_release |-> fast_charge_code == FAST_CHARGE_RST; endproperty
    property p_pre_rst;
        s_release |-> {current_step_select, precharge_code} == {1'b0, PRECHARGE_RST[4:0]};
    endproperty
    property p_term_rst; s_release |-> termination_cfg == TERMINATION_RST; endproperty
    property p_irq_quiet; s_release |-> charge_irq_n [*2]; endproperty
    property p_sat; regulation_code <= BAT_REG_CODE_MAX; endproperty
    property p_fast_units;
        fast_charge_units == (9'(fast_charge_code) << current_step_select);
    endproperty
    property p_pre_units; precharge_units == (6'(precharge_code) << current_step_select); endproperty
    a_reg_rst: assert property (p_reg_rst)
        else $error("regulation reset");
    a_fast_rst: assert property (p_fast_rst)
        else $error("fast charge reset");
    a_pre_rst: assert property (p_pre_rst)
        else $error("precharge reset");
    a_term_rst: assert property (p_term_rst)
        else $error("termination reset");
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq after reset");
    a_sat: assert property (p_sat)
        else $error("regulation above cap");
    a_fast_units: assert property (p_fast_units)
        else $error("fast units");
    a_pre_units: assert property (p_pre_units)
        else $error("pre units");
endmodule

bind charger_reg_bank charger_reg_bank_chk chk (
    .core_clk, .reset_n, .charge_irq_n, .regulation_code, .fast_charge_code,
    .precharge_code, .current_step_select, .termination_cfg, .fast_charge_units,
    .precharge_units);

/* charger_host_model.sv */
// host model: serial link controller for the register bank
// assumes a pull-up on sda, resolved by the surrounding bench
`timescale 1ns/1ps
module charger_host_model #(
    parameter logic [6:0] TARGET = 7'h2a,  // arbitrary, matches the bank default
    parameter int         HALF   = 8
) (
    // clock
    input  wire logic clk,
    // serial link
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------------------------
    // link phases
    // ------------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt();
        repeat (HALF) @(posedge clk);
    endtask
    // sda moves mid low phase so data never mimics start or stop
    task automatic bit_io(input logic b, output logic r);
        wt();
        sda_low <= !b;
        wt();
        scl <= 1'b1;
        wt();
        r = sda_in;
        scl <= 1'b0;
    endtask
    // ninth bit released: device acks writes, host nacks reads
    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(1'b1, a);
    endtask
    // start when s is 0, stop when s is 1
    task automatic frame(input logic s);
        wt();
        sda_low <= s;
        wt();
        scl <= 1'b1;
        wt();
        sda_low <= !s;
        wt();
        if (!s) scl <= 1'b0;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        frame(1'b0);
        xfer({TARGET, 1'b0}, r);
        xfer(a, r);
        xfer(d, r);
        frame(1'b1);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        frame(1'b0);
        xfer({TARGET, 1'b0}, r);
        xfer(a, r);
        frame(1'b0);
        xfer({TARGET, 1'b1}, r);
        xfer(8'hff, d);
        frame(1'b1);
    endtask
endmodule

/* charger_irq_mask_and_charge_setpoints_test.sv */
// testbench: register bank reset values, masks, saturation, currents, interrupt
// assumes the host model and the checker bind are compiled alongside
`timescale 1ns/1ps
module charger_irq_mask_and_charge_setpoints_test
    import charger_regs_pkg::*;
;
    // ------------------------------------------------------------------
    // bench
    // ------------------------------------------------------------------
    logic        core_clk, reset_n, scl, host_low, sda_oe, sda_out, irq_n, step;
    logic [23:0] ev;
    logic [6:0]  reg_code;
    logic [7:0]  fc_code, term;
    logic [4:0]  pc_code;
    logic [8:0]  fc_u;
    logic [5:0]  pc_u;
    int          error_cnt = 0;
    int          checked = 0;
    logic [31:0] seed = 32'hcd1521a7;
    wire         sda = !(host_low || (sda_oe && !sda_out));  // pull-up when released
    charger_reg_bank dut (.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .fault_event(ev[7:0]), .adc_event(ev[15:8]),
        .timer_event(ev[23:16]), .charge_irq_n(irq_n), .regulation_code(reg_code),
        .fast_charge_code(fc_code), .precharge_code(pc_code), .current_step_select(step),
        .termination_cfg(term), .fast_charge_units(fc_u), .precharge_units(pc_u));
    charger_host_model host (.clk(core_clk), .sda_in(sda), .scl(scl), .sda_low(host_low));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] sat(input logic [7:0] v);
        return {v[7], (v[6:0] > BAT_REG_CODE_MAX) ? BAT_REG_CODE_MAX : v[6:0]};
    endfunction
    task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(a, d);
        chk($sformatf("reg %h", a), 9'(d), 9'(e));
    endtask
    // one-cycle event, then let flag and irq registers settle
    task automatic pulse(input int n);
        @(posedge core_clk);
        ev <= 24'h1 << n;
        @(posedge core_clk);
        ev <= '0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // bound: well above the expected run
    initial begin
        repeat (95000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] v, e;
        logic [7:0] vt[4] = '{8'h70, 8'h64, 8'h63, 8'hff};
        logic [7:0] vld[3] = '{FAULT_FLAG_VALID, ADC_FLAG_VALID, TIMER_FLAG_VALID};
        int g, b;
        ev = '0;
        reset_n = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd_chk(FAULT_IRQ_MASK_OFS, FAULT_IRQ_MASK_RST);
        rd_chk(ADC_IRQ_MASK_OFS, ADC_IRQ_MASK_RST);
        rd_chk(TIMER_IRQ_MASK_OFS, TIMER_IRQ_MASK_RST);
        rd_chk(BAT_REG_VOLT_OFS, {1'b0, BAT_REG_CODE_RST});
        rd_chk(FAST_CHARGE_OFS, FAST_CHARGE_RST);
        rd_chk(PRECHARGE_OFS, PRECHARGE_RST);
        rd_chk(TERMINATION_OFS, TERMINATION_RST);
        rd_chk(8'h30, UNMAPPED_READ);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            host.write_reg(FAULT_IRQ_MASK_OFS + 8'(i), v);
            rd_chk(FAULT_IRQ_MASK_OFS + 8'(i), v);
        end
        $display("masks done");
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? vt[i] : rnd();
            e = sat(v);
            host.write_reg(BAT_REG_VOLT_OFS, v);
            rd_chk(BAT_REG_VOLT_OFS, e);
            chk("regulation", 9'(reg_code), 9'(e[6:0]));
        end
        $display("regulation done");
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            v[7] = i[0];
            e = rnd();
            host.write_reg(PRECHARGE_OFS, v);
            host.write_reg(FAST_CHARGE_OFS, e);
            rd_chk(PRECHARGE_OFS, v & PRECHARGE_WR_MASK);
            chk("step", 9'(step), 9'(v[7]));
            chk("fast units", fc_u, 9'(e) << v[7]);
            chk("pre units", 9'(pc_u), 9'(v[4:0]) << v[7]);
        end
        $display("currents done");
        for (int i = 0; i < 3; i++) begin
            host.write_reg(FAULT_IRQ_MASK_OFS + 8'(i), 8'hff);
            rd_chk(FAULT_FLAG_OFS + 8'(i), FLAG_RST);
        end
        for (int i = 0; i < 5; i++) begin
            g = (i == 0) ? 0 : int'(rnd()) % 3;
            b = (i == 0) ? 7 : int'(rnd()) % 8;
            while (!vld[g][b]) b = (b + 1) % 8;
            pulse(g * 8 + b);
            chk("irq masked", 9'(irq_n), 9'h1);
            rd_chk(FAULT_FLAG_OFS + 8'(g), 8'h1 << b);
            host.write_reg(FAULT_IRQ_MASK_OFS + 8'(g), ~(8'h1 << b));
            pulse(g * 8 + b);
            chk("irq open", 9'(irq_n), 9'h0);
            rd_chk(FAULT_FLAG_OFS + 8'(g), 8'h1 << b);
            repeat (4) @(posedge core_clk);
            chk("irq cleared", 9'(irq_n), 9'h1);
            host.write_reg(FAULT_IRQ_MASK_OFS + 8'(g), 8'hff);
        end
        $display("irq done");
        report_and_stop();
    end
endmodule
